/* File: hdl/cpc_pkg.sv */
package cpc_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int NREG = 6;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [IDX_W-1:0] IDX_PLL_CTRL = 10'h010;
    localparam logic [IDX_W-1:0] IDX_ABL = 10'h017;
    localparam logic [IDX_W-1:0] IDX_CAL = 10'h018;
    localparam logic [IDX_W-1:0] IDX_PDIV = 10'h1e0;
    localparam logic [IDX_W-1:0] IDX_DSRC = 10'h1e1;
    localparam logic [IDX_W-1:0] IDX_CPCUR = 10'h1f0;
    localparam logic [IDX_W-1:0] IDX_STAT = 10'h1f1;
    localparam logic [IDX_W-1:0] IDX_UPD = 10'h232;

    // Slot order of the shadowed registers
    localparam int S_PLL = 0;
    localparam int S_ABL = 1;
    localparam int S_CAL = 2;
    localparam int S_PDIV = 3;
    localparam int S_DSRC = 4;
    localparam int S_CPCUR = 5;
    localparam logic [IDX_W-1:0] REG_IDX [NREG] = '{IDX_PLL_CTRL, IDX_ABL, IDX_CAL,
                                                    IDX_PDIV, IDX_DSRC, IDX_CPCUR};
    localparam logic [7:0] REG_MASK [NREG] = '{8'hf3, 8'h03, 8'h01, 8'h07, 8'h03, 8'h07};
    localparam logic [7:0] REG_RST [NREG] = '{8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};

    // ==========================================================
    // Field positions and codes
    localparam int PWR_LSB = 0;
    localparam int CPM_LSB = 4;
    localparam int POL_BIT = 7;
    localparam int CAL_BIT = 0;
    localparam int BYP_BIT = 0;
    localparam int SRC_BIT = 1;
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_ASYNC_PD = 2'h1;
    localparam logic [2:0] CPM_HIZ = 3'h0;
    localparam logic [2:0] CPM_UP = 3'h1;
    localparam logic [2:0] CPM_DOWN = 3'h2;
    localparam logic [2:0] CPM_NORMAL = 3'h3;
    localparam logic [7:0] UPD_CODE = 8'h01;
    localparam logic [2:0] PDIV_MAX_CODE = 3'h4;
    localparam logic [2:0] PDIV_BASE = 3'h2;
    localparam logic [3:0] ABL_BASE_CYCLES = 4'h1;
    localparam int ST_CAL_BUSY = 0;
    localparam int ST_CAL_DONE = 1;
    localparam int ST_PDIV_RSVD = 2;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int CAL_TIME_NS = 2000;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: hdl/cpc_postdiv.sv */
`timescale 1ns/100ps
module cpc_postdiv (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic in_tick,
    input wire logic bypass,
    input wire logic [2:0] ratio_code,
    // Result
    output logic out_tick,
    output logic code_reserved
);
    import cpc_pkg::*;

    logic [2:0] cnt;
    wire logic [2:0] last = ratio_code + 3'h1;
    wire logic valid = (ratio_code <= PDIV_MAX_CODE);
    wire logic wrap = in_tick && (cnt == last);

    assign code_reserved = !valid;

    // Reserved codes leave the divider static rather than guessing a ratio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 3'h0;
        end else if (bypass || !valid || wrap) begin
            cnt <= 3'h0;
        end else if (in_tick) begin
            cnt <= cnt + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_tick <= 1'b0;
        end else begin
            out_tick <= bypass ? in_tick : (valid && wrap);
        end
    end

endmodule

/* File: hdl/cpc_pfd.sv */
`timescale 1ns/100ps
module cpc_pfd (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Settings
    input wire logic enable,
    input wire logic polarity_neg,
    input wire logic [1:0] abl_code,
    input wire logic [2:0] cp_mode,
    // Divider edges
    input wire logic ref_rise,
    input wire logic fb_rise,
    // Pump commands
    output logic pump_up,
    output logic pump_down,
    output logic pump_hiz
);
    import cpc_pkg::*;

    logic up_q;
    logic dn_q;
    logic [3:0] abl_cnt;
    wire logic both = up_q && dn_q;
    wire logic abl_end = both && (abl_cnt >= ABL_BASE_CYCLES + {2'b00, abl_code});
    wire logic run = enable && (cp_mode == CPM_NORMAL);
    wire logic lead = polarity_neg ? dn_q : up_q;
    wire logic lag = polarity_neg ? up_q : dn_q;
    logic next_up;
    logic next_dn;

    always_comb begin
        next_up = 1'b0;
        next_dn = 1'b0;
        if (!enable) begin
            next_up = 1'b0;
        end else if (cp_mode == CPM_UP) begin
            next_up = 1'b1;
        end else if (cp_mode == CPM_DOWN) begin
            next_dn = 1'b1;
        end else if (run) begin
            next_up = lead;
            next_dn = lag;
        end
    end

    // Both sides stay on for the antibacklash width to kill the dead zone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
            abl_cnt <= 4'h0;
        end else if (!run || abl_end) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
            abl_cnt <= 4'h0;
        end else begin
            up_q <= up_q || ref_rise;
            dn_q <= dn_q || fb_rise;
            abl_cnt <= both ? abl_cnt + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_up <= 1'b0;
            pump_down <= 1'b0;
            pump_hiz <= 1'b1;
        end else begin
            pump_up <= next_up;
            pump_down <= next_dn;
            pump_hiz <= !enable || !(run || cp_mode == CPM_UP || cp_mode == CPM_DOWN);
        end
    end

endmodule

/* File: hdl/cpc_top.sv */
// Function
// - Power field 00 runs PLL, 01 powers down
// - Bypass bit 0 uses post-divider, 1 bypasses
// - Source bit 1 oscillator, 0 external clock
// - Post-divider ratio field selects 2 to 6
// - Calibration bit set plus update starts calibration (here only when the committed bit was 0 and no run is in progress)
// - Settings go active only on update 0x01
// - Polarity 0 positive, 1 negative
// - Antibacklash field sets dead-zone pulse width
// - Pump mode: hiz, normal, forced up, down
// - Pump current code has eight steps
// - Detector compares dividers, commands pump direction
// - Reset: PLL down, ratio four, divider, external
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module cpc_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [cpc_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins from the clock path
    input wire logic ref_div_in,
    input wire logic fb_div_in,
    input wire logic osc_clk_in,
    input wire logic ext_clk_in,
    // Clock path controls
    output logic pll_power_down,
    output logic dist_src_osc,
    output logic postdiv_bypass,
    output logic dist_tick,
    output logic osc_cal_start,
    output logic osc_cal_busy,
    // Charge pump
    output logic pump_up,
    output logic pump_down,
    output logic pump_hiz,
    output logic [2:0] pump_current_code
);
    import cpc_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    wire logic [3:0] pins = {ext_clk_in, osc_clk_in, fb_div_in, ref_div_in};
    wire logic [3:0] rise = sync2 & ~sync3;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pins[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // APB decode
    wire logic [IDX_W-1:0] idx = paddr[ADDR_W-1:2];
    wire logic aligned = (paddr[1:0] == 2'b00);
    wire logic access = psel && penable;
    wire logic setup = psel && !penable;
    wire logic wr_lane = pwrite && pstrb[0];
    wire logic [7:0] wbyte = pwdata[7:0];
    wire logic hit_upd = aligned && (idx == IDX_UPD);
    wire logic hit_stat = aligned && (idx == IDX_STAT);
    logic [NREG-1:0] hit_reg;
    wire logic mapped = (|hit_reg) || hit_upd || hit_stat;
    wire logic wr_ok = access && wr_lane && pready;

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ==========================================================
    // Shadow and active registers
    logic [7:0] shadow [NREG];
    logic [7:0] active [NREG];
    wire logic upd_pulse = wr_ok && hit_upd && (wbyte == UPD_CODE);

    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            assign hit_reg[gi] = aligned && (idx == REG_IDX[gi]);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    shadow[gi] <= REG_RST[gi];
                end else if (wr_ok && hit_reg[gi]) begin
                    shadow[gi] <= wbyte & REG_MASK[gi];
                end
            end
            // Nothing reaches the hardware until software commits it
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    active[gi] <= REG_RST[gi];
                end else if (upd_pulse) begin
                    active[gi] <= shadow[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Active fields
    wire logic [1:0] act_pwr = active[S_PLL][PWR_LSB +: 2];
    wire logic [2:0] act_cpm = active[S_PLL][CPM_LSB +: 3];
    wire logic act_pol = active[S_PLL][POL_BIT];
    wire logic [1:0] act_abl = active[S_ABL][1:0];
    wire logic act_cal = active[S_CAL][CAL_BIT];
    wire logic [2:0] act_ratio = active[S_PDIV][2:0];
    wire logic act_byp = active[S_DSRC][BYP_BIT];
    wire logic act_src = active[S_DSRC][SRC_BIT];
    wire logic pll_on = (act_pwr == PWR_NORMAL);

    // Only 00 runs the loop; every other code is treated as powered down
    assign pll_power_down = !pll_on;
    assign dist_src_osc = act_src;
    assign postdiv_bypass = act_byp;
    assign pump_current_code = active[S_CPCUR][2:0];

    // ==========================================================
    // Distribution source and post-divider
    wire logic src_tick = act_src ? rise[2] : rise[3];
    logic pdiv_rsvd;

    cpc_postdiv u_postdiv (
        .pclk(pclk),
        .presetn(presetn),
        .in_tick(src_tick),
        .bypass(act_byp),
        .ratio_code(act_ratio),
        .out_tick(dist_tick),
        .code_reserved(pdiv_rsvd)
    );

    // ==========================================================
    // Phase detector and charge pump
    cpc_pfd u_pfd (
        .pclk(pclk),
        .presetn(presetn),
        .enable(pll_on),
        .polarity_neg(act_pol),
        .abl_code(act_abl),
        .cp_mode(act_cpm),
        .ref_rise(rise[0]),
        .fb_rise(rise[1]),
        .pump_up(pump_up),
        .pump_down(pump_down),
        .pump_hiz(pump_hiz)
    );

    // ==========================================================
    // Oscillator calibration
    typedef enum logic [1:0] {CPC_IDLE, CPC_START, CPC_RUN} cpc_cal_t;
    cpc_cal_t cal_state;
    cpc_cal_t next_cal_state;
    logic [15:0] cal_cnt;
    logic cal_done;
    // Only a 0 to 1 edge of the committed bit starts a run, so a
    // repeat needs the clear-then-set sequence from software
    wire logic cal_req = upd_pulse && shadow[S_CAL][CAL_BIT] && !act_cal;
    wire logic cal_last = (cal_cnt == 16'(CAL_CYCLES - 1));
    wire logic done_set = (cal_state == CPC_RUN) && cal_last;
    wire logic done_clr = wr_ok && hit_stat && wbyte[ST_CAL_DONE];

    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            CPC_IDLE: begin
                if (cal_req) begin
                    next_cal_state = CPC_START;
                end
            end
            CPC_START: begin
                next_cal_state = CPC_RUN;
            end
            CPC_RUN: begin
                if (cal_last) begin
                    next_cal_state = CPC_IDLE;
                end
            end
            default: begin
                next_cal_state = CPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_state <= CPC_IDLE;
            cal_cnt <= 16'h0000;
        end else begin
            cal_state <= next_cal_state;
            cal_cnt <= (cal_state == CPC_RUN) ? cal_cnt + 16'h0001 : 16'h0000;
        end
    end

    // Completion wins over a simultaneous software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_done <= 1'b0;
        end else if (done_set) begin
            cal_done <= 1'b1;
        end else if (done_clr) begin
            cal_done <= 1'b0;
        end
    end

    assign osc_cal_start = (cal_state == CPC_START);
    assign osc_cal_busy = (cal_state != CPC_IDLE);

    // ==========================================================
    // Read data
    logic [7:0] rd_byte;
    wire logic [7:0] stat_byte = {5'h00, pdiv_rsvd, cal_done, osc_cal_busy};

    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (hit_reg[i]) begin
                rd_byte = shadow[i];
            end
        end
        if (hit_stat) begin
            rd_byte = stat_byte;
        end
    end

    // Captured in setup so the zero-wait access phase sees it stable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata <= {24'h000000, rd_byte};
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_update_commit: assert property (
        upd_pulse |=> active[S_PLL] == $past(shadow[S_PLL])
                      && active[S_DSRC] == $past(shadow[S_DSRC]))
        else $error("Update did not commit the pending settings");

    a_hold_no_update: assert property (
        !upd_pulse |=> $stable(active[S_PDIV]) && $stable(active[S_PLL]))
        else $error("Active settings changed without an update");

    // Pump flops lag the committed power field by one cycle
    a_power_field: assert property (
        (act_pwr == PWR_ASYNC_PD) |-> pll_power_down ##1 (pump_hiz && !pump_up && !pump_down))
        else $error("Powered-down PLL is still driving the pump");

    a_source_tick: assert property (
        act_byp && !act_src && rise[3] && !upd_pulse |=> dist_tick)
        else $error("External clock tick not passed to distribution");

    a_bypass_path: assert property (
        act_byp && !src_tick && !upd_pulse |=> !dist_tick)
        else $error("Bypassed path produced a tick without a source edge");

    a_ratio_reserved: assert property (
        act_ratio > PDIV_MAX_CODE && !act_byp && $stable(act_ratio) |=> !dist_tick)
        else $error("Reserved ratio code let the divider run");

    a_cal_start: assert property (
        cal_req && cal_state == CPC_IDLE |=> osc_cal_start ##1 !osc_cal_start && osc_cal_busy)
        else $error("Calibration did not start after the commit");

    a_cal_length: assert property (
        osc_cal_busy |-> cal_cnt < 16'(CAL_CYCLES))
        else $error("Calibration ran past its length");

    a_cal_needs_edge: assert property (
        upd_pulse && act_cal && shadow[S_CAL][CAL_BIT] && !osc_cal_busy |=> !osc_cal_start)
        else $error("Calibration restarted without a clear first");

    a_forced_up: assert property (
        pll_on && act_cpm == CPM_UP && !upd_pulse |=> pump_up && !pump_down && !pump_hiz)
        else $error("Forced pump-up mode not honoured");

    a_pump_hiz: assert property (
        act_cpm == CPM_HIZ && !upd_pulse |=> pump_hiz && !pump_up && !pump_down)
        else $error("High-impedance pump mode still drives");

    a_reset_defaults: assert property (
        $rose(presetn) |-> pll_power_down && !dist_src_osc && !postdiv_bypass
                           && act_ratio == 3'h2)
        else $error("Wrong settings after reset");

    a_unmapped_err: assert property (
        access && !mapped |-> pslverr && pready)
        else $error("Unmapped access not flagged");

    c_update: cover property (upd_pulse ##1 pll_on);
    c_cal_run: cover property (osc_cal_start ##[1:300] cal_done);
    c_forced_down: cover property (pll_on && act_cpm == CPM_DOWN ##1 pump_down);
    c_divided_tick: cover property (!act_byp && dist_tick);

endmodule

/* File: verif/tb_clock_path_pll_config.sv */
`timescale 1ns/100ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %0t %s", $time, m); end end
module tb_clock_path_pll_config;
    import cpc_pkg::*;
    // ==========================================================
    // Signals
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb, pin;
    logic pready, pslverr, err, pll_power_down, dist_src_osc, postdiv_bypass, dist_tick;
    logic osc_cal_start, osc_cal_busy, pump_up, pump_down, pump_hiz;
    logic [2:0] pump_current_code, prev;
    int miscompares, n_tests, n_tick, n_start, n_busy, n_both, t0, t1;

    cpc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_div_in(pin[2]),
        .fb_div_in(pin[3]), .osc_clk_in(pin[1]), .ext_clk_in(pin[0]),
        .pll_power_down(pll_power_down), .dist_src_osc(dist_src_osc),
        .postdiv_bypass(postdiv_bypass), .dist_tick(dist_tick),
        .osc_cal_start(osc_cal_start), .osc_cal_busy(osc_cal_busy), .pump_up(pump_up),
        .pump_down(pump_down), .pump_hiz(pump_hiz), .pump_current_code(pump_current_code));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Mid-cycle sampling keeps the counters clear of edge races
    always @(negedge pclk) begin
        if (dist_tick === 1'b1) n_tick++;
        if (osc_cal_start === 1'b1) n_start++;
        if (osc_cal_busy === 1'b1) n_busy++;
        if (pump_up === 1'b1 && pump_down === 1'b1) n_both++;
    end

    // ==========================================================
    // Bus and pin helpers
    task automatic end_sim;
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            miscompares++;
            $display("ERROR %0t bus access timed out", $time);
            end_sim();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 8'h00);
        `CHK(rdat, e, "register read")
    endtask

    task automatic upd;
        wr(IDX_UPD, UPD_CODE);
    endtask

    // Slow square edges on one pin, then room for the sync latency
    task automatic edges(input int k, input int n);
        repeat (n) begin
            pin[k] <= 1'b1;
            repeat (4) @(posedge pclk);
            pin[k] <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_vals;
        rd(IDX_PLL_CTRL, 32'h1);
        rd(IDX_PDIV, 32'h2);
        rd(IDX_DSRC, 32'h0);
        `CHK(pll_power_down, 1'b1, "power after reset")
        `CHK({dist_src_osc, postdiv_bypass}, 2'b00, "path after reset")
    endtask

    task automatic t_update;
        wr(IDX_PLL_CTRL, 8'h30);
        `CHK(pll_power_down, 1'b1, "early effect")
        rd(IDX_PLL_CTRL, 32'h30);
        wr(IDX_UPD, 8'h02);
        `CHK(pll_power_down, 1'b1, "bad update code took effect")
        upd();
        `CHK(pll_power_down, 1'b0, "pll not running")
        wr(IDX_PLL_CTRL, 8'h31);
        upd();
        `CHK(pll_power_down, 1'b1, "pll not down")
    endtask

    task automatic t_source;
        wr(IDX_DSRC, 8'h01);
        upd();
        `CHK({dist_src_osc, postdiv_bypass}, 2'b01, "external bypass")
        t0 = n_tick;
        edges(0, 7);
        `CHK(n_tick - t0, 7, "external bypass ticks")
        t0 = n_tick;
        edges(1, 6);
        `CHK(n_tick - t0, 0, "unselected source ticked")
        // Oscillator selected with the bypass bit clear, so the post-divider stays in the path
        wr(IDX_DSRC, 8'h02);
        upd();
        `CHK({dist_src_osc, postdiv_bypass}, 2'b10, "oscillator via divider")
        t0 = n_tick;
        edges(1, 8);
        `CHK(n_tick - t0, 2, "oscillator divided ticks")
        t0 = n_tick;
        edges(0, 8);
        `CHK(n_tick - t0, 0, "external ticked with oscillator")
        wr(IDX_DSRC, 8'h01);
        upd();
    endtask

    task automatic t_cal;
        t0 = n_start;
        t1 = n_busy;
        wr(IDX_CAL, 8'h01);
        `CHK(n_start - t0, 0, "calibration before update")
        upd();
        repeat (260) @(posedge pclk);
        `CHK(n_start - t0, 1, "calibration start")
        `CHK(n_busy - t1, 1 + CAL_CYCLES, "calibration length")
        rd(IDX_STAT, 32'h2);
        wr(IDX_STAT, 8'h02);
        rd(IDX_STAT, 32'h0);
        upd();
        repeat (10) @(posedge pclk);
        `CHK(n_start - t0, 1, "restart without clearing")
        wr(IDX_CAL, 8'h00);
        upd();
        wr(IDX_CAL, 8'h01);
        upd();
        repeat (260) @(posedge pclk);
        `CHK(n_start - t0, 2, "second calibration")
    endtask

    task automatic t_pfd;
        wr(IDX_PLL_CTRL, 8'h30);
        for (int c = 0; c < 4; c++) begin
            wr(IDX_ABL, 8'(c));
            upd();
            edges(2, 1);
            `CHK({pump_up, pump_down}, 2'b10, "reference lead")
            t0 = n_both;
            edges(3, 1);
            `CHK(n_both - t0, int'(ABL_BASE_CYCLES) + c + 1, "overlap width")
            `CHK({pump_up, pump_down}, 2'b00, "pump not cleared")
        end
        wr(IDX_PLL_CTRL, 8'hb0);
        upd();
        edges(2, 1);
        `CHK({pump_up, pump_down}, 2'b01, "negative polarity")
        edges(3, 1);
        wr(IDX_PLL_CTRL, 8'h10);
        upd();
        repeat (3) @(posedge pclk);
        `CHK({pump_up, pump_down, pump_hiz}, 3'b100, "forced up")
        wr(IDX_PLL_CTRL, 8'h20);
        upd();
        repeat (3) @(posedge pclk);
        `CHK({pump_up, pump_down, pump_hiz}, 3'b010, "forced down")
        wr(IDX_PLL_CTRL, 8'h00);
        upd();
        repeat (3) @(posedge pclk);
        `CHK({pump_up, pump_down, pump_hiz}, 3'b001, "holdover")
    endtask

    task automatic t_cur;
        prev = 3'h0;
        for (int k = 0; k < 8; k++) begin
            wr(IDX_CPCUR, 8'(k));
            `CHK(pump_current_code, prev, "current before update")
            upd();
            `CHK(pump_current_code, 3'(k), "current step")
            prev = 3'(k);
        end
        apb(1'b0, 10'h001, 8'h00);
        `CHK({err, rdat}, {1'b1, 32'h0}, "unmapped read")
    endtask

    // Reset before each code so the divider phase starts at zero
    task automatic t_ratio;
        do_reset();
        t0 = n_tick;
        edges(0, 60);
        `CHK(n_tick - t0, 15, "default ratio")
        for (int c = 0; c < 6; c++) begin
            do_reset();
            wr(IDX_PDIV, 8'(c));
            upd();
            t0 = n_tick;
            edges(0, 60);
            `CHK(n_tick - t0, (c < 5) ? 60 / (c + 2) : 0, "ratio ticks")
        end
        rd(IDX_STAT, 32'h4);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        pin = 4'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_vals();
        t_update();
        t_source();
        t_cal();
        t_pfd();
        t_cur();
        t_ratio();
        end_sim();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        $display("ERROR %0t run did not finish", $time);
        end_sim();
    end
endmodule
